/* verilog/tmctl_timer.sv */
// Purpose: Sixteen-bit timer with control registers and low power
// Assumes: Single byte register port, reads answer next cycle
`timescale 1ns/1ps
module tmctl_timer #(
   parameter bit EXT_PRESENT = 1'b1
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Register port
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   // Power and processor
   input  wire logic       waitMode,
   input  wire logic       haltMode,
   input  wire logic       irqWake,
   input  wire logic       globalMask,
   // Pins
   input  wire logic       captureInputPinOne,
   input  wire logic       captureInputPinTwo,
   input  wire logic       externalCountPin,
   output logic            compareOutputPinOne,
   output logic            compareOutputPinTwo,
   output logic            compareEnableOne,
   output logic            compareEnableTwo,
   output logic            timerIrq,
   output logic            wakeRequest
);
   typedef struct packed {
      logic [7:0]  ctlOne;
      logic [7:0]  ctlTwo;
      logic        capTwoIen;
      logic [15:0] count;
      logic [15:0] cmpOne;
      logic [15:0] cmpTwo;
      logic [15:0] capOne;
      logic [15:0] capTwo;
      logic [7:0]  cmpHiBuf;
      logic        capFlagOne;
      logic        capFlagTwo;
      logic        cmpFlagOne;
      logic        cmpFlagTwo;
      logic        ovfFlag;
      logic [4:0]  statusSeen;
      logic        capPrevOne;
      logic        capPrevTwo;
      logic        armOne;
      logic        armTwo;
      logic        wasHalt;
      logic        pinOne;
      logic        pinTwo;
      logic        enOne;
      logic        enTwo;
      logic        irq;
      logic        wake;
      logic [7:0]  rdData;
   } tmctl_state_t;
   tmctl_state_t st, next_st;

   logic tick;
   logic pwmMode, onePulse;
   logic edgeOne, edgeTwo, matchOne, matchTwo, irqAny;
   logic [7:0] rdMux;

   // ************************************************
   // Prescaler
   // ************************************************
   tmctl_prescaler u_pre (
      .sys_clk          (sys_clk),
      .reset            (reset),
      .hold             (haltMode),
      .clockSelect      (st.ctlTwo[tmctl_pkg::CR2_CLK_HI:
                                   tmctl_pkg::CR2_CLK_LO]),
      .extClockEdge     (st.ctlTwo[tmctl_pkg::CR2_EXT_EDGE]),
      .extPresent       (EXT_PRESENT),
      .externalCountPin (externalCountPin),
      .tick             (tick)
   );

   // ************************************************
   // Decoded conditions
   // ************************************************
   always_comb begin
      pwmMode  = st.ctlTwo[tmctl_pkg::CR2_PWM];
      onePulse = st.ctlTwo[tmctl_pkg::CR2_ONE_PULSE] && !pwmMode;
      edgeOne  = st.ctlOne[tmctl_pkg::CR1_EDGE_ONE] ?
                 (captureInputPinOne && !st.capPrevOne) :
                 (!captureInputPinOne && st.capPrevOne);
      edgeTwo  = st.ctlTwo[tmctl_pkg::CR2_EDGE_TWO] ?
                 (captureInputPinTwo && !st.capPrevTwo) :
                 (!captureInputPinTwo && st.capPrevTwo);
      matchOne = tick && (st.count == st.cmpOne);
      matchTwo = tick && (st.count == st.cmpTwo);
      irqAny   = (st.ctlOne[tmctl_pkg::CR1_CAPT_IEN] &&
                  (st.capFlagOne || st.capFlagTwo)) ||
                 (st.ctlOne[tmctl_pkg::CR1_CMP_IEN] &&
                  (st.cmpFlagOne || st.cmpFlagTwo)) ||
                 (st.ctlOne[tmctl_pkg::CR1_OVF_IEN] && st.ovfFlag);
   end

   // ************************************************
   // Read mux
   // ************************************************
   always_comb begin
      case (regAddr)
         tmctl_pkg::OFS_CONTROL_ONE: rdMux = st.ctlOne;
         tmctl_pkg::OFS_CONTROL_TWO: rdMux = st.ctlTwo;
         tmctl_pkg::OFS_STATUS: rdMux = {st.capFlagOne, st.cmpFlagOne,
            st.ovfFlag, st.capFlagTwo, st.cmpFlagTwo, 3'h0};
         tmctl_pkg::OFS_CAPT1_HI:  rdMux = st.capOne[15:8];
         tmctl_pkg::OFS_CAPT1_LO:  rdMux = st.capOne[7:0];
         tmctl_pkg::OFS_CMP1_HI:   rdMux = st.cmpOne[15:8];
         tmctl_pkg::OFS_CMP1_LO:   rdMux = st.cmpOne[7:0];
         tmctl_pkg::OFS_CMP2_HI:   rdMux = st.cmpTwo[15:8];
         tmctl_pkg::OFS_CMP2_LO:   rdMux = st.cmpTwo[7:0];
         tmctl_pkg::OFS_COUNT_HI:  rdMux = st.count[15:8];
         tmctl_pkg::OFS_COUNT_LO:  rdMux = st.count[7:0];
         tmctl_pkg::OFS_CAPT2_HI:  rdMux = st.capTwo[15:8];
         tmctl_pkg::OFS_CAPT2_LO:  rdMux = st.capTwo[7:0];
         tmctl_pkg::OFS_CAPT2_IEN: rdMux = {7'h00, st.capTwoIen};
         default:                  rdMux = 8'h00;
      endcase
   end

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      logic acc;
      logic [4:0] seen;
      logic [4:0] clrHit;
      acc  = regRead || regWrite;
      seen = st.statusSeen;
      clrHit = 5'h00;
      next_st = st;
      // Flags hold only this cycle's sets here; old values merged below
      next_st.capFlagOne = 1'b0;
      next_st.capFlagTwo = 1'b0;
      next_st.cmpFlagOne = 1'b0;
      next_st.cmpFlagTwo = 1'b0;
      next_st.ovfFlag    = 1'b0;
      next_st.rdData = regRead ? rdMux : 8'h00;
      next_st.wasHalt = haltMode;
      // Counter, waiting runs as normal
      if (tick && !haltMode) begin
         next_st.count = st.count + 16'h0001;
         if (st.count == 16'hFFFF)
            next_st.ovfFlag = 1'b1;
      end
      // Capture inputs
      next_st.capPrevOne = captureInputPinOne;
      next_st.capPrevTwo = captureInputPinTwo;
      if (haltMode) begin
         if (edgeOne && !pwmMode && !onePulse)
            next_st.armOne = 1'b1;
         if (edgeTwo)
            next_st.armTwo = 1'b1;
      end else begin
         if (st.wasHalt && irqWake) begin
            if (st.armOne) begin
               next_st.capFlagOne = 1'b1;
               next_st.capOne = st.count;
            end
            if (st.armTwo) begin
               next_st.capFlagTwo = 1'b1;
               next_st.capTwo = st.count;
            end
         end
         if (st.wasHalt) begin
            next_st.armOne = 1'b0;
            next_st.armTwo = 1'b0;
         end
         if (edgeOne && !pwmMode) begin
            next_st.capFlagOne = 1'b1;
            if (onePulse) begin
               next_st.count = tmctl_pkg::COUNT_RESET;
               next_st.capOne = tmctl_pkg::PULSE_CAPT;
               next_st.pinOne = st.ctlOne[tmctl_pkg::CR1_LEVEL_TWO];
            end else
               next_st.capOne = st.count;
         end
         if (edgeTwo) begin
            next_st.capFlagTwo = 1'b1;
            next_st.capTwo = st.count;
         end
      end
      // Compare one
      if (matchOne && !haltMode) begin
         if (!pwmMode && !onePulse)
            next_st.cmpFlagOne = 1'b1;
         if (pwmMode || onePulse || st.ctlTwo[tmctl_pkg::CR2_PIN_ONE_EN])
            next_st.pinOne = st.ctlOne[tmctl_pkg::CR1_LEVEL_ONE];
      end
      // Compare two, PWM period end
      if (matchTwo && !haltMode) begin
         if (pwmMode) begin
            next_st.count = tmctl_pkg::COUNT_RESET;
            next_st.capFlagOne = 1'b1;
            next_st.pinOne = st.ctlOne[tmctl_pkg::CR1_LEVEL_TWO];
         end else begin
            next_st.cmpFlagTwo = 1'b1;
            if (!onePulse)
               next_st.pinTwo = st.ctlOne[tmctl_pkg::CR1_LEVEL_TWO];
         end
      end
      // Forced levels, ignored in pulse modes
      if (!pwmMode && !onePulse) begin
         if (st.ctlOne[tmctl_pkg::CR1_FORCE_ONE])
            next_st.pinOne = st.ctlOne[tmctl_pkg::CR1_LEVEL_ONE];
         if (st.ctlOne[tmctl_pkg::CR1_FORCE_TWO])
            next_st.pinTwo = st.ctlOne[tmctl_pkg::CR1_LEVEL_TWO];
      end
      // Flag clear: status read then data access; set wins
      if (regRead && regAddr == tmctl_pkg::OFS_STATUS)
         seen = {st.capFlagOne, st.cmpFlagOne, st.ovfFlag,
                 st.capFlagTwo, st.cmpFlagTwo};
      if (acc) begin
         clrHit[4] = st.statusSeen[4] && regAddr == tmctl_pkg::OFS_CAPT1_LO;
         clrHit[3] = st.statusSeen[3] && regAddr == tmctl_pkg::OFS_CMP1_LO;
         clrHit[2] = st.statusSeen[2] && regAddr == tmctl_pkg::OFS_COUNT_LO;
         clrHit[1] = st.statusSeen[1] && regAddr == tmctl_pkg::OFS_CAPT2_LO;
         clrHit[0] = st.statusSeen[0] && regAddr == tmctl_pkg::OFS_CMP2_LO;
      end
      seen = seen & ~clrHit;
      // A set in the clearing cycle survives the clear
      next_st.capFlagOne = next_st.capFlagOne | (st.capFlagOne & ~clrHit[4]);
      next_st.cmpFlagOne = next_st.cmpFlagOne | (st.cmpFlagOne & ~clrHit[3]);
      next_st.ovfFlag    = next_st.ovfFlag | (st.ovfFlag & ~clrHit[2]);
      next_st.capFlagTwo = next_st.capFlagTwo | (st.capFlagTwo & ~clrHit[1]);
      next_st.cmpFlagTwo = next_st.cmpFlagTwo | (st.cmpFlagTwo & ~clrHit[0]);
      next_st.statusSeen = seen;
      // Register writes
      if (regWrite) begin
         case (regAddr)
            tmctl_pkg::OFS_CONTROL_ONE: next_st.ctlOne = regWrData;
            tmctl_pkg::OFS_CONTROL_TWO: next_st.ctlTwo = regWrData;
            tmctl_pkg::OFS_CMP1_HI, tmctl_pkg::OFS_CMP2_HI:
               next_st.cmpHiBuf = regWrData;
            tmctl_pkg::OFS_CMP1_LO:
               next_st.cmpOne = {st.cmpHiBuf, regWrData};
            tmctl_pkg::OFS_CMP2_LO:
               next_st.cmpTwo = {st.cmpHiBuf, regWrData};
            tmctl_pkg::OFS_COUNT_LO:
               next_st.count = tmctl_pkg::COUNT_RESET;
            tmctl_pkg::OFS_CAPT2_IEN: next_st.capTwoIen = regWrData[0];
            default: ;
         endcase
      end
      // Pin enables and shared request
      next_st.enOne = st.ctlTwo[tmctl_pkg::CR2_PIN_ONE_EN];
      next_st.enTwo = st.ctlTwo[tmctl_pkg::CR2_PIN_TWO_EN];
      next_st.irq   = irqAny && !globalMask;
      // No timer event leaves halt
      next_st.wake  = irqAny && waitMode && !haltMode;
   end

   // ************************************************
   // Registers
   // ************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st <= '0;
         st.ctlOne <= tmctl_pkg::CONTROL_RESET;
         st.ctlTwo <= tmctl_pkg::CONTROL_RESET;
         st.count  <= tmctl_pkg::COUNT_RESET;
         st.cmpOne <= tmctl_pkg::CMP_RESET;
         st.cmpTwo <= tmctl_pkg::CMP_RESET;
      end else
         st <= next_st;
   end

   assign regRdData           = st.rdData;
   assign compareOutputPinOne = st.pinOne;
   assign compareOutputPinTwo = st.pinTwo;
   assign compareEnableOne    = st.enOne;
   assign compareEnableTwo    = st.enTwo;
   assign timerIrq            = st.irq;
   assign wakeRequest         = st.wake;
endmodule

/* verilog/tmctl_pkg.sv */
// Purpose: Shared constants for the timer control block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Offsets are register indices on the local port
package tmctl_pkg;
   // ************************************************
   // Register offsets
   // ************************************************
   localparam logic [3:0] OFS_CONTROL_ONE = 4'h0;
   localparam logic [3:0] OFS_CONTROL_TWO = 4'h1;
   localparam logic [3:0] OFS_STATUS      = 4'h2;
   localparam logic [3:0] OFS_CAPT1_HI    = 4'h3;
   localparam logic [3:0] OFS_CAPT1_LO    = 4'h4;
   localparam logic [3:0] OFS_CMP1_HI     = 4'h5;
   localparam logic [3:0] OFS_CMP1_LO     = 4'h6;
   localparam logic [3:0] OFS_CMP2_HI     = 4'h7;
   localparam logic [3:0] OFS_CMP2_LO     = 4'h8;
   localparam logic [3:0] OFS_COUNT_HI    = 4'h9;
   localparam logic [3:0] OFS_COUNT_LO    = 4'hA;
   localparam logic [3:0] OFS_CAPT2_HI    = 4'hB;
   localparam logic [3:0] OFS_CAPT2_LO    = 4'hC;
   localparam logic [3:0] OFS_CAPT2_IEN   = 4'hD;
   // ************************************************
   // Control register one fields
   // ************************************************
   localparam int CR1_CAPT_IEN  = 7;
   localparam int CR1_CMP_IEN   = 6;
   localparam int CR1_OVF_IEN   = 5;
   localparam int CR1_FORCE_TWO = 4;
   localparam int CR1_FORCE_ONE = 3;
   localparam int CR1_LEVEL_TWO = 2;
   localparam int CR1_EDGE_ONE  = 1;
   localparam int CR1_LEVEL_ONE = 0;
   // ************************************************
   // Control register two fields
   // ************************************************
   localparam int CR2_PIN_ONE_EN = 7;
   localparam int CR2_PIN_TWO_EN = 6;
   localparam int CR2_ONE_PULSE  = 5;
   localparam int CR2_PWM        = 4;
   localparam int CR2_CLK_HI     = 3;
   localparam int CR2_CLK_LO     = 2;
   localparam int CR2_EDGE_TWO   = 1;
   localparam int CR2_EXT_EDGE   = 0;
   // ************************************************
   // Status fields
   // ************************************************
   localparam int SR_CAPT_ONE = 7;
   localparam int SR_CMP_ONE  = 6;
   localparam int SR_OVF      = 5;
   localparam int SR_CAPT_TWO = 4;
   localparam int SR_CMP_TWO  = 3;
   // ************************************************
   // Reset values and counts
   // ************************************************
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'hFFFC;
   localparam logic [15:0] CMP_RESET     = 16'h8000;
   localparam logic [15:0] PULSE_CAPT    = 16'hFFFD;
   localparam logic [1:0]  CLK_DIV4      = 2'h0;
   localparam logic [1:0]  CLK_DIV2      = 2'h1;
   localparam logic [1:0]  CLK_DIV8      = 2'h2;
   localparam logic [1:0]  CLK_EXT       = 2'h3;
   typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_HALT} tmctl_power_t;
endpackage

/* verilog/tmctl_prescaler.sv */
// Purpose: Timer tick generator from CPU clock or external pin
// Assumes: External pin synchronous to sys_clk
// Notes:   Prescaler frozen while hold is high
`timescale 1ns/1ps
module tmctl_prescaler (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // Control
   input  wire logic       hold,
   input  wire logic [1:0] clockSelect,
   input  wire logic       extClockEdge,
   input  wire logic       extPresent,
   input  wire logic       externalCountPin,
   // Tick
   output logic            tick
);
   typedef struct packed {
      logic [2:0] div;
      logic       extPrev;
      logic       tick;
   } tmctl_pre_t;
   tmctl_pre_t st, next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      next_st.extPrev = externalCountPin;
      if (!hold) begin
         next_st.div = st.div + 3'h1;
         case (clockSelect)
            tmctl_pkg::CLK_DIV4: next_st.tick = (st.div[1:0] == 2'h3);
            tmctl_pkg::CLK_DIV2: next_st.tick = st.div[0];
            tmctl_pkg::CLK_DIV8: next_st.tick = (st.div == 3'h7);
            default: begin
               // Missing pin means a stopped counter
               next_st.tick = extPresent && (extClockEdge ?
                  (externalCountPin && !st.extPrev) :
                  (!externalCountPin && st.extPrev));
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign tick = st.tick;
endmodule

/* verification/tmctl_asserts.sv */
// Purpose: Port assertions for the timer control block
// Assumes: Control registers shadowed from port writes
// Notes:   Pin levels are judged by the bench
`timescale 1ns/1ps
module tmctl_asserts (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       reset,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrite,
   input wire logic       regRead,
   input wire logic [7:0] regRdData,
   // Power and outputs
   input wire logic       waitMode,
   input wire logic       haltMode,
   input wire logic       globalMask,
   input wire logic       compareEnableOne,
   input wire logic       compareEnableTwo,
   input wire logic       timerIrq,
   input wire logic       wakeRequest
);
   logic [7:0] ctlOne;
   logic [7:0] ctlTwo;
   logic       noIen;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctlOne <= 8'h00;
         ctlTwo <= 8'h00;
      end else if (regWrite) begin
         if (regAddr == tmctl_pkg::OFS_CONTROL_ONE)
            ctlOne <= regWrData;
         if (regAddr == tmctl_pkg::OFS_CONTROL_TWO)
            ctlTwo <= regWrData;
      end
   end
   // No capture, compare or overflow enable
   assign noIen = (ctlOne[7:5] == 3'h0);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_rd(logic [3:0] a);
      regRead && regAddr == a;
   endsequence
   a_ctl_one_read: assert property (
      s_rd(tmctl_pkg::OFS_CONTROL_ONE) |=> regRdData == ctlOne)
      else $error("control one read back wrong");
   a_ctl_two_read: assert property (
      s_rd(tmctl_pkg::OFS_CONTROL_TWO) |=> regRdData == ctlTwo)
      else $error("control two read back wrong");
   a_irq_masked: assert property (
      globalMask && $past(globalMask) |-> !timerIrq)
      else $error("request while masked");
   a_irq_enable_gate: assert property (
      noIen && $past(noIen) |-> !timerIrq)
      else $error("request with all enables off");
   a_halt_no_wake: assert property (
      haltMode && $past(haltMode) |-> !wakeRequest)
      else $error("timer wake during halt");
   a_run_no_wake: assert property (
      !waitMode && $past(!waitMode) |-> !wakeRequest)
      else $error("wake outside wait");
   a_wait_enable_gate: assert property (
      noIen && $past(noIen) |-> !wakeRequest)
      else $error("wake with all enables off");
   a_pin_one_own: assert property (
      $stable(ctlTwo[7]) |-> compareEnableOne == ctlTwo[7])
      else $error("pin one ownership wrong");
   a_pin_two_own: assert property (
      $stable(ctlTwo[6]) |-> compareEnableTwo == ctlTwo[6])
      else $error("pin two ownership wrong");
endmodule
bind tmctl_timer tmctl_asserts i_tmctl_asserts (.sys_clk, .reset,
   .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .waitMode,
   .haltMode, .globalMask, .compareEnableOne, .compareEnableTwo,
   .timerIrq, .wakeRequest);

/* verification/tb.sv */
// Purpose: Self-checking bench for the timer control block
// Assumes: Count read through its low byte at a fixed phase
// Notes:   Rate checks use deltas so prescaler phase drops out
`timescale 1ns/1ps
module tb;
   logic       sys_clk = 1'b0;
   logic       reset = 1'b1;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00;
   logic       regWrite = 1'b0;
   logic       regRead = 1'b0;
   logic       waitMode = 1'b0;
   logic       haltMode = 1'b0;
   logic       irqWake = 1'b0;
   logic       globalMask = 1'b1;
   logic       capOne = 1'b0;
   logic       capTwo = 1'b0;
   logic       extPin = 1'b0;
   logic [7:0] regRdData;
   logic       pinOne, pinTwo, enOne, enTwo, timerIrq, wakeRequest;
   logic [7:0] d, h;
   logic       seenHi, seenLo;
   int         num_errors = 0;
   int         tests_run = 0;
   int         cycles = 0;
   always #12.5 sys_clk = ~sys_clk;
   tmctl_timer i_tmctl_timer (.sys_clk, .reset, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData, .waitMode, .haltMode, .irqWake,
      .globalMask, .captureInputPinOne(capOne),
      .captureInputPinTwo(capTwo), .externalCountPin(extPin),
      .compareOutputPinOne(pinOne), .compareOutputPinTwo(pinTwo),
      .compareEnableOne(enOne), .compareEnableTwo(enTwo),
      .timerIrq, .wakeRequest);
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic conclude();
      $display("Errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Runaway guard, well above the planned run
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         conclude();
      end
   end
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      tests_run++;
      if (g !== x) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic chk1(input logic g, input logic x);
      chk8({7'h00, g}, {7'h00, x});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      // Step past the edge so outputs have settled
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= v;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1 v = regRdData;
   endtask
   // One status read arms every flag set at that time; clr repeats it before each low byte
   task automatic clr();
      logic [3:0] lo [5] = '{4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
      foreach (lo[i]) begin
         rd(tmctl_pkg::OFS_STATUS, d);
         rd(lo[i], d);
      end
   endtask
   // Count advance over exactly 64 clocks
   task automatic dlt(output logic [7:0] n);
      logic [7:0] a;
      rd(4'hA, a);
      cyc(62);
      rd(4'hA, n);
      n = n - a;
   endtask
   task automatic ext(input logic [7:0] v);
      logic [7:0] a;
      wr(4'h1, v);
      rd(4'hA, a);
      repeat (5) begin
         cyc(8);
         extPin <= ~extPin;
      end
      cyc(8);
      rd(4'hA, d);
      chk8(d - a, 8'h03);
   endtask
   // ************************************************
   // Scenarios
   // ************************************************
   task automatic t_reset();
      rd(4'h0, d);
      chk8(d, 8'h00);
      rd(4'h1, d);
      chk8(d, 8'h00);
      chk1(enOne | enTwo | timerIrq, 1'b0);
      wr(4'hF, 8'hFF);
      rd(4'hF, d);
      chk8(d, 8'h00);
      wr(4'h0, 8'hA5);
      rd(4'h0, d);
      chk8(d, 8'hA5);
   endtask
   task automatic t_force();
      wr(4'h1, 8'hC0);
      wr(4'h0, 8'h1D);
      cyc(20);
      chk1(pinOne, 1'b1);
      chk1(pinTwo, 1'b1);
      wr(4'h0, 8'h18);
      cyc(20);
      chk1(pinOne, 1'b0);
      chk1(pinTwo, 1'b0);
   endtask
   task automatic t_overflow();
      wr(4'h0, 8'h00);
      clr();
      wr(4'hA, 8'h00);
      wr(4'h0, 8'h20);
      cyc(40);
      chk1(timerIrq, 1'b0);
      globalMask <= 1'b0;
      cyc(3);
      chk1(timerIrq, 1'b1);
      wr(4'h0, 8'h00);
      cyc(2);
      chk1(timerIrq, 1'b0);
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_OVF], 1'b1);
   endtask
   task automatic t_rates();
      logic [7:0] x [3] = '{8'd16, 8'd32, 8'd8};
      for (int s = 0; s < 3; s++) begin
         wr(4'h1, {4'h0, 2'(s), 2'b00});
         dlt(d);
         chk8(d, x[s]);
      end
      ext(8'h0D);
      ext(8'h0C);
      wr(4'h1, 8'h00);
      haltMode <= 1'b1;
      dlt(d);
      chk8(d, 8'h00);
      haltMode <= 1'b0;
      irqWake <= 1'b1;
      cyc(2);
      irqWake <= 1'b0;
      dlt(d);
      chk8(d, 8'd16);
      waitMode <= 1'b1;
      dlt(d);
      chk8(d, 8'd16);
      waitMode <= 1'b0;
   endtask
   task automatic t_capture();
      wr(4'h0, 8'h80);
      clr();
      capOne <= 1'b1;
      cyc(4);
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_CAPT_ONE], 1'b0);
      capOne <= 1'b0;
      cyc(4);
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_CAPT_ONE], 1'b1);
      chk1(timerIrq, 1'b1);
      waitMode <= 1'b1;
      cyc(3);
      chk1(wakeRequest, 1'b1);
      waitMode <= 1'b0;
      clr();
      wr(4'h1, 8'h02);
      capTwo <= 1'b1;
      cyc(4);
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_CAPT_TWO], 1'b1);
      clr();
      capTwo <= 1'b0;
      cyc(4);
      haltMode <= 1'b1;
      rd(4'hA, h);
      capTwo <= 1'b1;
      cyc(4);
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_CAPT_TWO], 1'b0);
      haltMode <= 1'b0;
      irqWake <= 1'b1;
      cyc(2);
      irqWake <= 1'b0;
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_CAPT_TWO], 1'b1);
      rd(4'hC, d);
      chk8(d, h);
   endtask
   task automatic t_pwm();
      wr(4'h0, 8'h04);
      clr();
      wr(4'h7, 8'h00);
      wr(4'h8, 8'h10);
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h08);
      wr(4'h0, 8'h44);
      wr(4'h1, 8'hB0);
      // Restart so the period match comes soon
      wr(4'hA, 8'h00);
      seenHi = 1'b0;
      seenLo = 1'b0;
      repeat (400) begin
         @(posedge sys_clk);
         #1 seenHi = seenHi | (pinOne === 1'b1);
         seenLo = seenLo | (pinOne === 1'b0);
      end
      chk1(seenHi & seenLo, 1'b1);
      chk1(timerIrq, 1'b0);
      rd(4'h2, d);
      chk1(d[tmctl_pkg::SR_CAPT_ONE], 1'b1);
      chk1(d[tmctl_pkg::SR_CMP_ONE] | d[tmctl_pkg::SR_CMP_TWO], 1'b0);
   endtask
   task automatic t_compare();
      wr(4'h1, 8'hC0);
      wr(4'h0, 8'h18);
      cyc(10);
      clr();
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h10);
      wr(4'h7, 8'h00);
      wr(4'h8, 8'h20);
      wr(4'hA, 8'h00);
      // Forced low until the count restarts, so no stale match
      wr(4'h0, 8'h05);
      cyc(40);
      chk1(pinOne, 1'b0);
      cyc(60);
      chk1(pinOne, 1'b1);
      chk1(pinTwo, 1'b0);
      cyc(80);
      chk1(pinTwo, 1'b1);
      chk1(timerIrq, 1'b0);
      wr(4'h0, 8'h45);
      cyc(3);
      chk1(timerIrq, 1'b1);
   endtask
   task automatic t_pulse();
      wr(4'h0, 8'h04);
      wr(4'h5, 8'h00);
      wr(4'h6, 8'h10);
      wr(4'h1, 8'hA0);
      capOne <= 1'b1;
      cyc(4);
      capOne <= 1'b0;
      cyc(8);
      chk1(pinOne, 1'b1);
      rd(4'h4, d);
      chk8(d, 8'hFD);
      cyc(100);
      chk1(pinOne, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      t_reset();
      t_force();
      t_overflow();
      t_rates();
      t_capture();
      t_pwm();
      t_compare();
      t_pulse();
      conclude();
   end
endmodule
